// >>> logic/rbt_timer.sv
// programmable sixteen-stage binary timer with an apb register port
//
// Behaviour
// (R1) select code 00/01/10/11 picks stage 13/10/8/16 as output
// (R2) code 10 clocks the ninth stage straight from the count clock
// (R3) recycle mode: output follows chosen stage, period 2^n counts
// (R4) power-on clear runs when its disable input is low
// (R5) master clear high resets the counter, low lets it run
// (R6) every reset clears all stages together
// (R7) while in reset the output equals the polarity select
// (R8) mode high is recycle, mode low is single cycle
// (R9) single cycle: after 2^(n-1) counts latch sets, output flips once
// (R10) latched output holds until master clear or mode change
// (R11) clear pulse restarts; high polarity stays high until count
// (R12) one-shot retriggers on any new clear pulse
// (R13) an external count clock may replace the internal oscillator
// (R14) user waits one pulse width after power-up before trusting it
// (R15) stages advance on count clock rising edge, each halves rate
// (R16) internal oscillator is held stopped during any reset
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rbt_timer
  import rbt_pkg::*;
#(
  parameter int unsigned OSC_DIV  = OSC_CYCLES,
  parameter int unsigned POR_HOLD = POR_CYCLES,
  parameter int unsigned ADDR_W   = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              master_clear_in,
  input  wire logic              power_on_clear_disable,
  input  wire logic              osc_sense_in,
  output logic                   timer_q_out
);

  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  if (OSC_DIV < 1) begin : g_bad_div
    $error("rbt_timer: OSC_DIV must be at least 1");
  end
  if (POR_HOLD < 1) begin : g_bad_por
    $error("rbt_timer: POR_HOLD must be at least 1");
  end
  if (ADDR_W < 8) begin : g_bad_addr
    $error("rbt_timer: ADDR_W must be at least 8");
  end

  localparam int unsigned DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
  localparam int unsigned POR_W = $clog2(POR_HOLD + 1);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;
  logic              q_reg;
  logic              q_next;
  logic [DIV_W-1:0]  div_reg;
  logic              osc_tick;
  logic              sense_prev_reg;
  logic              ext_tick;
  logic              tick;
  logic              por_arm_reg;
  logic [POR_W-1:0]  por_cnt_reg;
  logic              mode_prev_reg;
  logic              mode_chg;
  logic              clr_any;
  logic              bypass;
  logic              sel_bit;
  logic [STAGES-1:0] count;
  logic              in_reset;
  rbt_state_t        state_reg;
  rbt_state_t        state_next;
  rbt_tsel_t         tsel;
  logic              mode_recycle;
  logic              pol;
  logic              ext_sel;
  logic              soft_clear;
  logic              setup_phase;
  logic              wr_take;
  logic              hit_ctrl;
  logic              hit_status;
  logic [31:0]       status_word;

  rbt_chain_if #(.W(LOW_STAGES))          lo_if ();
  rbt_chain_if #(.W(STAGES - LOW_STAGES)) hi_if ();

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  assign tsel         = rbt_tsel_t'(ctrl_reg[CTRL_TSEL_LSB +: 2]);
  assign mode_recycle = ctrl_reg[CTRL_MODE_BIT];
  assign pol          = ctrl_reg[CTRL_POL_BIT];
  assign ext_sel      = ctrl_reg[CTRL_EXT_BIT];
  assign soft_clear   = ctrl_reg[CTRL_CLR_BIT];

  // ------------------------------------------------------------
  // power-on clear
  // ------------------------------------------------------------
  // the disable pin is a level caught after reset release, so the
  // arm flag only takes a constant under the asynchronous reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_arm_reg <= 1'b1;
    end else if (power_on_clear_disable) begin
      por_arm_reg <= 1'b0; // R4
    end else if (por_cnt_reg == POR_W'(POR_HOLD - 1)) begin
      por_arm_reg <= 1'b0; // R4
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= '0;
    end else if (por_arm_reg) begin
      por_cnt_reg <= por_cnt_reg + POR_W'(1);
    end
  end

  // ------------------------------------------------------------
  // reset sources
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_prev_reg <= CTRL_RESET[CTRL_MODE_BIT];
    end else begin
      mode_prev_reg <= mode_recycle;
    end
  end

  // a change of mode level restarts a finished single cycle
  assign mode_chg = mode_prev_reg != mode_recycle; // R10

  // master clear acts regardless of the power-on function
  assign clr_any = master_clear_in // R5
                 | soft_clear
                 | (por_arm_reg & ~power_on_clear_disable) // R4
                 | mode_chg;

  // ------------------------------------------------------------
  // count clock
  // ------------------------------------------------------------
  // divider stands at zero during reset, so the first count after
  // release comes a full oscillator period later
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
    end else if (clr_any || ext_sel) begin
      div_reg <= '0; // R16
    end else if (div_reg == DIV_W'(OSC_DIV - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DIV_W'(1);
    end
  end

  assign osc_tick = ~clr_any & ~ext_sel
                  & (div_reg == DIV_W'(OSC_DIV - 1)); // R16

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_prev_reg <= 1'b0;
    end else begin
      sense_prev_reg <= osc_sense_in;
    end
  end

  // external clock counts on its rising edge
  assign ext_tick = ext_sel & osc_sense_in & ~sense_prev_reg; // R13
  assign tick     = ext_tick | osc_tick; // R13

  // ------------------------------------------------------------
  // counter stages
  // ------------------------------------------------------------
  assign bypass = (tsel == TSEL_8);

  // low stages stall when the ninth stage takes the count clock
  assign lo_if.adv = tick & ~bypass; // R2
  assign lo_if.clr = clr_any; // R6
  assign hi_if.adv = bypass ? tick : lo_if.carry; // R2
  assign hi_if.clr = clr_any; // R6

  rbt_stage_chain #(.W(LOW_STAGES)) u_low (
    .clk   (core_clk),
    .rst_n (rst_n),
    .grp   (lo_if)
  );

  rbt_stage_chain #(.W(STAGES - LOW_STAGES)) u_high (
    .clk   (core_clk),
    .rst_n (rst_n),
    .grp   (hi_if)
  );

  assign count = {hi_if.val, lo_if.val};

  // stage n toggles every 2^(n-1) counts
  always_comb begin
    unique case (tsel)
      TSEL_13: sel_bit = count[12]; // R1
      TSEL_10: sel_bit = count[9]; // R1
      TSEL_8:  sel_bit = count[STAGES-1]; // R2
      TSEL_16: sel_bit = count[STAGES-1]; // R1
    endcase
  end

  // ------------------------------------------------------------
  // single-cycle latch
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clr_any) begin
      state_next = ST_CLEAR; // R12
    end else begin
      unique case (state_reg)
        ST_CLEAR: state_next = ST_RUN; // R9
        ST_RUN: begin
          if (!mode_recycle && sel_bit) begin
            state_next = ST_HELD; // R9
          end
        end
        ST_HELD: state_next = ST_HELD; // R10
        default: state_next = ST_CLEAR;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_CLEAR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign in_reset = clr_any | (state_reg == ST_CLEAR);

  // ------------------------------------------------------------
  // output
  // ------------------------------------------------------------
  // the run case also looks at the running bit so that the output
  // flips in the same cycle in both modes
  always_comb begin
    if (clr_any) begin
      q_next = pol; // R7
    end else if (mode_recycle) begin
      q_next = pol ^ sel_bit; // R3 R8
    end else if (state_reg == ST_HELD) begin
      q_next = ~pol; // R10 R11
    end else begin
      q_next = pol ^ (sel_bit & (state_reg == ST_RUN)); // R9 R11
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= CTRL_RESET[CTRL_POL_BIT];
    end else begin
      q_reg <= q_next;
    end
  end

  assign timer_q_out = q_reg;

  // ------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------
  // answer is prepared in the setup cycle, so every access completes
  // in its first access cycle with no wait state
  assign setup_phase = psel & ~penable;
  assign wr_take     = psel & penable & pready_reg & pwrite;
  assign hit_ctrl    = paddr == ADDR_W'(CTRL_OFFSET);
  assign hit_status  = paddr == ADDR_W'(STATUS_OFFSET);

  always_comb begin
    status_word                = '0;
    status_word[STAGES-1:0]    = count;
    status_word[STAT_Q_BIT]    = q_reg;
    status_word[STAT_HELD_BIT] = state_reg == ST_HELD;
    status_word[STAT_RST_BIT]  = in_reset;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
    end else begin
      pready_reg <= setup_phase;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      pslverr_reg <= ~(hit_ctrl | hit_status);
    end else begin
      pslverr_reg <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= '0;
    end else if (setup_phase && !pwrite && hit_ctrl) begin
      prdata_reg <= {{(32 - CTRL_W){1'b0}}, ctrl_reg};
    end else if (setup_phase && !pwrite && hit_status) begin
      prdata_reg <= status_word;
    end else if (setup_phase) begin
      prdata_reg <= '0;
    end
  end

  // control fields sit in byte lane 0; the status word ignores writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
    end else if (wr_take && hit_ctrl && pstrb[0]) begin
      ctrl_reg <= pwdata[CTRL_W-1:0]; // R8
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule

// >>> logic/rbt_pkg.sv
// constants, field layout and types shared by the binary timer
package rbt_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  // power-on clear hold time, a least time so it rounds up
  localparam int unsigned POR_TIME_NS   = 1000;
  localparam int unsigned POR_CYCLES    =
    (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // internal oscillator period, a nominal rate so it rounds down
  localparam int unsigned OSC_PERIOD_NS = 100000;
  localparam int unsigned OSC_CYCLES    = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // counter geometry
  // ------------------------------------------------------------
  localparam int unsigned STAGES     = 16;
  localparam int unsigned LOW_STAGES = 8;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
  localparam int unsigned CTRL_TSEL_LSB  = 0;
  localparam int unsigned CTRL_MODE_BIT  = 2;
  localparam int unsigned CTRL_POL_BIT   = 3;
  localparam int unsigned CTRL_EXT_BIT   = 4;
  localparam int unsigned CTRL_CLR_BIT   = 5;
  localparam int unsigned CTRL_W         = 6;
  localparam logic [5:0]  CTRL_RESET     = 6'h04;
  localparam int unsigned STAT_Q_BIT     = 16;
  localparam int unsigned STAT_HELD_BIT  = 17;
  localparam int unsigned STAT_RST_BIT   = 18;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  // select code, first select input is the upper bit
  typedef enum logic [1:0] {
    TSEL_13 = 2'h0,
    TSEL_10 = 2'h1,
    TSEL_8  = 2'h2,
    TSEL_16 = 2'h3
  } rbt_tsel_t;

  typedef enum logic [1:0] {
    ST_CLEAR = 2'h0,
    ST_RUN   = 2'h1,
    ST_HELD  = 2'h3
  } rbt_state_t;

endpackage

// >>> logic/rbt_chain_if.sv
// carrier between the timer core and one group of counter stages
`timescale 1ns/1ps
interface rbt_chain_if #(parameter int W = 8);
  logic         adv;
  logic         clr;
  logic [W-1:0] val;
  logic         carry;
  modport core  (output adv, output clr, input val, input carry);
  modport chain (input adv, input clr, output val, output carry);
endinterface

// >>> logic/rbt_stage_chain.sv
// one group of binary divide-by-two counter stages
`timescale 1ns/1ps
module rbt_stage_chain
  import rbt_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic    clk,
  input wire logic    rst_n,
  rbt_chain_if.chain  grp
);

  if (W < 1) begin : g_bad_width
    $error("rbt_stage_chain: W must be at least 1");
  end

  logic [W-1:0] val_reg;

  // all stages clear in the same cycle, whatever their state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_reg <= '0;
    end else if (grp.clr) begin
      val_reg <= '0; // R6
    end else if (grp.adv) begin
      val_reg <= val_reg + W'(1); // R15
    end
  end

  assign grp.val   = val_reg;
  // carry marks the tick on which the last stage of the group wraps
  assign grp.carry = grp.adv & (&val_reg);

endmodule

// >>> dv/rbt_timer_sva.sv
// port checker for the binary timer
`timescale 1ns/1ps
module rbt_timer_sva
  import rbt_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  input wire logic              master_clear_in,
  input wire logic              timer_q_out
);
  // shadow of clr, pol, mode; the design's own copy is not visible
  logic [2:0] ctl_reg;
  logic       wr;
  logic       mapd;
  logic       srd;
  assign mapd = paddr == CTRL_OFFSET || paddr == STATUS_OFFSET;
  assign wr = psel && penable && pready && pwrite && pstrb[0]
    && paddr == CTRL_OFFSET;
  assign srd = psel && !penable && !pwrite && paddr == STATUS_OFFSET;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= 3'h1;
    end else if (wr) begin
      ctl_reg <= {pwdata[CTRL_CLR_BIT], pwdata[CTRL_POL_BIT],
                  pwdata[CTRL_MODE_BIT]};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held");
  a_err_map: assert property (psel && !penable && !mapd |=> pslverr)
    else $error("unmapped access accepted");
  a_ok_map: assert property (psel && !penable && mapd |=> !pslverr)
    else $error("mapped access refused");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  a_clear_pol: assert property (
    (master_clear_in || ctl_reg[2]) && !wr |=> timer_q_out == ctl_reg[1])
    else $error("output not at polarity in clear");
  a_clear_stat: assert property (srd && master_clear_in
    && $past(master_clear_in)
    |=> prdata[15:0] == 16'h0 && prdata[STAT_RST_BIT])
    else $error("counter not cleared");
  a_latch_hold: assert property (!ctl_reg[0] && !ctl_reg[2] && !wr
    && !master_clear_in && timer_q_out != ctl_reg[1] && $stable(ctl_reg[0])
    |=> timer_q_out != ctl_reg[1])
    else $error("single cycle output changed");
endmodule
bind rbt_timer rbt_timer_sva #(.ADDR_W(ADDR_W)) u_sva (
  .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .pready, .prdata, .pslverr, .master_clear_in, .timer_q_out
);

// >>> dv/rbt_far_side.sv
// external count clock source for the timer's sense input
`timescale 1ns/1ps
module rbt_far_side (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic [1:0] half,
  output logic            tick_out
);
  logic [1:0] cnt_reg;
  initial tick_out = 1'b0;
  initial cnt_reg = 2'h0;
  // half sets the half period: 0 is the fastest the sync input takes
  always @(posedge clk) begin
    if (!run) begin
      tick_out <= 1'b0;
      cnt_reg  <= 2'h0;
    end else begin
      cnt_reg <= (cnt_reg == half) ? 2'h0 : cnt_reg + 2'h1;
      if (cnt_reg == half) begin
        tick_out <= ~tick_out;
      end
    end
  end
endmodule

// >>> dv/tb_rbt_timer.sv
// self-checking bench for the binary timer
`timescale 1ns/1ps
`define CHK(a, b) begin \
  checks++; \
  if ((a) !== (b)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  end \
end
module tb_rbt_timer
  import rbt_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        master_clear_in = 1'b1;
  logic        power_on_clear_disable = 1'b0;
  logic        osc_sense_in;
  logic        timer_q_out;
  logic        run = 1'b0;
  logic [1:0]  half = 2'h0;
  logic [31:0] d;
  logic        e;
  logic        sense_d1 = 1'b0;
  logic        sense_d2 = 1'b0;
  int          num_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  rbt_timer #(.OSC_DIV(4), .POR_HOLD(2), .ADDR_W(8)) u_dut (
    .core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .master_clear_in,
    .power_on_clear_disable, .osc_sense_in, .timer_q_out
  );
  rbt_far_side u_far (.clk(core_clk), .run, .half, .tick_out(osc_sense_in));
  // sense history as the timer samples it, so a tick is counted on the
  // edge the counter takes it, whatever the half period
  always @(posedge core_clk) begin
    sense_d1 <= osc_sense_in;
    sense_d2 <= sense_d1;
  end
  initial forever #25 core_clk = ~core_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic conclude;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // counts ticks taken by the counter until the output moves or lim
  task automatic flips(input int lim, output int k);
    logic q0;
    q0 = timer_q_out;
    k = 0;
    while (k < lim) begin
      @(negedge core_clk);
      if (timer_q_out !== q0) break;
      if (sense_d1 && !sense_d2) k++;
    end
    @(posedge core_clk);
  endtask
  // mid-run reset with the power-on hold enabled or disabled
  task automatic t_por(input logic dis, input logic [15:0] exp);
    master_clear_in        <= 1'b0;
    power_on_clear_disable <= dis;
    rst_n                  <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0, d, e);
    `CHK(d[15:0], exp)
  endtask
  task automatic t_regs;
    master_clear_in <= 1'b0;
    bus(1'b0, CTRL_OFFSET, 32'h0, d, e);
    `CHK(d, 32'h4)
    bus(1'b0, 8'h08, 32'h0, d, e);
    `CHK({e, d}, 33'h1_0000_0000)
    bus(1'b1, CTRL_OFFSET, 32'h2c, d, e);
    bus(1'b1, STATUS_OFFSET, 32'hffff, d, e);
    repeat (20) @(posedge core_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0, d, e);
    `CHK(d[18:0], 19'h5_0000)
    bus(1'b1, CTRL_OFFSET, 32'h04, d, e);
    repeat (40) @(posedge core_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0, d, e);
    `CHK(d[15:0] inside {[16'd8:16'd13]}, 1'b1)
  endtask
  task automatic t_sel(input rbt_tsel_t t, input logic m, input logic p,
                       input logic [1:0] h, input int n, input logic r);
    int k;
    master_clear_in <= 1'b1;
    half <= h;
    bus(1'b1, CTRL_OFFSET, {26'h0, 2'b01, p, m, t}, d, e);
    bus(1'b0, STATUS_OFFSET, 32'h0, d, e);
    `CHK(d[15:0], 16'h0)
    `CHK(timer_q_out, p)
    master_clear_in <= 1'b0;
    run <= 1'b1;
    if (r) begin
      flips(1 << (n - 2), k);
      master_clear_in <= 1'b1;
      run <= 1'b0;
      @(posedge core_clk);
      master_clear_in <= 1'b0;
      run <= 1'b1;
    end
    flips(1 << n, k);
    `CHK(k, 1 << (n - 1))
    `CHK(timer_q_out, !p)
    if (m) begin
      flips(1 << n, k);
      `CHK(k, 1 << (n - 1))
      `CHK(timer_q_out, p)
    end else begin
      flips(100, k);
      `CHK(k, 100)
      bus(1'b1, CTRL_OFFSET, {26'h0, 2'b01, p, 1'b1, t}, d, e);
      bus(1'b0, STATUS_OFFSET, 32'h0, d, e);
      `CHK(d[STAT_HELD_BIT], 1'b0)
      `CHK(timer_q_out, p)
    end
    run <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence and timeout
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_regs;
    t_por(1'b1, 16'h1);
    t_por(1'b0, 16'h0);
    t_sel(TSEL_8, 1'b0, 1'b0, 2'h1, 8, 1'b1);
    t_sel(TSEL_10, 1'b1, 1'b1, 2'h0, 10, 1'b0);
    t_sel(TSEL_13, 1'b0, 1'b0, 2'h0, 13, 1'b0);
    t_sel(TSEL_16, 1'b0, 1'b1, 2'h0, 16, 1'b0);
    conclude;
  end
  // the longest one-shot needs about 66k cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      conclude;
    end
  end
endmodule
